//--- core/bpw_power_wake.v
// Power management core of a short-range radio: sleep/wake handshake,
// clock request, RF power-down controls, low-power modes and shutdown.
// Assumes one 100 MHz clock; wake and enable pins are asynchronous.
//
// Behaviour
// - Handshake lines act only in UART transport with handshake enabled.
// - Asserted device wake forces wake and blocks sleep.
// - Deasserted device wake allows sleep once internal criteria hold and software requests sleep.
// - Wake input and output polarities are independently software selectable.
// - Clock request high when radio is active, or when radio is enabled, not shut down and wireless LAN needs reference clock.
// - Clock request rises after radio enable rises at startup.
// - Separate power-down outputs for transmit, receive, PLL and amplifier.
// - Power actions come from software controls or packet handling.
// - RF sections powered only while a packet needs them.
// - Sniff, hold, park run on low-power clock and wake after interval.
// - Shutdown floats the host wake and clock request pins and disables most inputs.
// - Leaving shutdown is a full power-up with no retained state.
// - Radio reset held while radio enable is low.
`include "bpw_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bpw_power_wake #(
  parameter TIMER_W = `BPW_TIMER_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins from the host side
  input wire radio_enable_in,
  input wire device_wake_request,
  input wire low_power_osc_in,
  // Host wake pin
  output wire host_wake_request_o,
  output wire host_wake_request_oe,
  // Clock request pin
  output wire clk_request_o,
  output wire clk_request_oe,
  // Software controls
  input wire uart_mode,
  input wire handshake_en,
  input wire dev_wake_active_low,
  input wire host_wake_active_low,
  input wire sw_host_wake,
  input wire sw_sleep_req,
  input wire sw_shutdown,
  input wire [TIMER_W-1:0] sleep_interval,
  input wire [3:0] sw_pd_force,
  // Internal demand and packet handling
  input wire sleep_criteria_met,
  input wire wlan_clk_need,
  input wire pkt_tx_active,
  input wire pkt_rx_active,
  input wire pkt_pa_active,
  // Status and controls
  output wire [3:0] rf_power_down,
  output wire radio_por_active,
  output wire core_awake,
  output wire on_low_power_clock,
  output wire in_shutdown,
  output wire [2:0] power_state
);

  localparam ST_OFF = `BPW_ST_OFF;
  localparam ST_ACTIVE = `BPW_ST_ACTIVE;
  localparam ST_LOWPWR = `BPW_ST_LOWPWR;
  localparam ST_SHUTDOWN = `BPW_ST_SHUTDOWN;

  // State decode shared by several outputs
  function is_state;
    input [2:0] cur;
    input [2:0] want;
    begin
      is_state = (cur == want);
    end
  endfunction

  // Three-stage pin synchronisers
  reg [2:0] en_sync_q;
  reg [2:0] wake_sync_q;
  reg [2:0] lpo_sync_q;
  reg en_q;
  reg wake_raw_q;
  reg lpo_q;
  reg lpo_prev_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [TIMER_W-1:0] timer_q;
  reg [3:0] pd_q;
  reg host_wake_q;
  reg clk_req_q;

  // Decoded power states
  wire st_active = is_state(state_q, ST_ACTIVE);
  wire st_lowpwr = is_state(state_q, ST_LOWPWR);

  always @(posedge clk) begin
    if (rst) begin
      en_sync_q <= 3'h0;
      wake_sync_q <= 3'h0;
      lpo_sync_q <= 3'h0;
      en_q <= 1'b0;
      wake_raw_q <= 1'b0;
      lpo_q <= 1'b0;
      lpo_prev_q <= 1'b0;
    end else begin
      en_sync_q <= {en_sync_q[1:0], radio_enable_in};
      wake_sync_q <= {wake_sync_q[1:0], device_wake_request};
      lpo_sync_q <= {lpo_sync_q[1:0], low_power_osc_in};
      // A change counts once stages two and three agree
      if (en_sync_q[1] == en_sync_q[2])
        en_q <= en_sync_q[2];
      if (wake_sync_q[1] == wake_sync_q[2])
        wake_raw_q <= wake_sync_q[2];
      if (lpo_sync_q[1] == lpo_sync_q[2])
        lpo_q <= lpo_sync_q[2];
      lpo_prev_q <= lpo_q;
    end
  end

  wire wake_level = wake_raw_q ^ dev_wake_active_low;
  wire hs_on = uart_mode & handshake_en;
  wire dev_wake = hs_on & wake_level;
  // Rising edge of the slow clock
  wire lpo_tick = lpo_q & ~lpo_prev_q;
  wire may_sleep = ~dev_wake & sleep_criteria_met & sw_sleep_req;

  // Next power state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (en_q && !sw_shutdown)
          state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (sw_shutdown)
          state_d = ST_SHUTDOWN;
        else if (may_sleep)
          state_d = ST_LOWPWR;
      end
      // Nap ends on wake request or timer run-out
      ST_LOWPWR: begin
        if (sw_shutdown)
          state_d = ST_SHUTDOWN;
        else if (dev_wake || (lpo_tick && timer_q <= 1))
          state_d = ST_ACTIVE;
      end
      ST_SHUTDOWN: begin
        if (!sw_shutdown)
          state_d = ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
    if (!en_q)
      state_d = ST_OFF;
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_OFF;
      timer_q <= {TIMER_W{1'b0}};
      pd_q <= `BPW_RST_PD;
      host_wake_q <= 1'b0;
      clk_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Low-power interval timer
      // Count only while napping
      if (state_q != ST_LOWPWR)
        timer_q <= sleep_interval;
      else if (lpo_tick && timer_q != {TIMER_W{1'b0}})
        timer_q <= timer_q - 1'b1;
      if (state_q == ST_ACTIVE) begin
        pd_q[`BPW_PD_TX] <= sw_pd_force[`BPW_PD_TX] | ~pkt_tx_active;
        pd_q[`BPW_PD_RX] <= sw_pd_force[`BPW_PD_RX] | ~pkt_rx_active;
        pd_q[`BPW_PD_PLL] <= sw_pd_force[`BPW_PD_PLL] | ~(pkt_tx_active | pkt_rx_active);
        pd_q[`BPW_PD_PA] <= sw_pd_force[`BPW_PD_PA] | ~pkt_pa_active;
      end else begin
        // RF stays off outside the active state
        pd_q <= `BPW_RST_PD;
      end
      host_wake_q <= hs_on & sw_host_wake & st_active;
      clk_req_q <= st_active | (en_q & wlan_clk_need & (state_q != ST_SHUTDOWN));
    end
  end

  wire shut = (state_q == ST_SHUTDOWN);

  assign host_wake_request_o = host_wake_q ^ host_wake_active_low;
  assign host_wake_request_oe = ~shut & hs_on;
  assign clk_request_o = clk_req_q;
  assign clk_request_oe = ~shut;
  assign rf_power_down = pd_q;
  assign radio_por_active = ~en_q;
  assign core_awake = st_active;
  assign on_low_power_clock = st_lowpwr;
  assign in_shutdown = shut;
  assign power_state = state_q;

endmodule // bpw_power_wake

`default_nettype wire

//--- core/bpw_defs.vh
// Constants for the radio power and wake handshake block.
// Included by the power sequencer core; no logic here.
`ifndef BPW_DEFS_VH
`define BPW_DEFS_VH

// Power state encodings
`define BPW_ST_OFF 3'h0
`define BPW_ST_ACTIVE 3'h1
`define BPW_ST_LOWPWR 3'h2
`define BPW_ST_SHUTDOWN 3'h3

// Reset value and timer width
`define BPW_RST_PD 4'hf
`define BPW_TIMER_W 32

// Power-down bit positions
`define BPW_PD_TX 0
`define BPW_PD_RX 1
`define BPW_PD_PLL 2
`define BPW_PD_PA 3

`endif

//--- verification/bpw_host_model.sv
// Host side of the wake handshake pins.
// Assumes pin levels only; no clock.
`timescale 1ns/1ps
`default_nettype none
module bpw_host_model (
  // Host intent and polarities
  input wire logic want,
  input wire logic dev_wake_active_low,
  input wire logic host_wake_active_low,
  // Handshake pins
  input wire logic host_wake_request_o,
  input wire logic host_wake_request_oe,
  output logic device_wake_request,
  output logic host_awake
);
  assign device_wake_request = want ^ dev_wake_active_low;
  assign host_awake = host_wake_request_oe & (host_wake_request_o ^ host_wake_active_low);
endmodule // bpw_host_model
`default_nettype wire

//--- verification/bpw_power_wake_checker.sv
// Port assertions for the power and wake block.
// Bound by name to every instance of it.
`timescale 1ns/1ps
`default_nettype none
module bpw_checker (
  // Clock and controls
  input wire logic clk,
  input wire logic rst,
  input wire logic uart_mode,
  input wire logic handshake_en,
  // Outputs
  input wire logic host_wake_request_oe,
  input wire logic clk_request_o,
  input wire logic clk_request_oe,
  input wire logic radio_por_active,
  input wire logic on_low_power_clock,
  input wire logic in_shutdown,
  input wire logic [2:0] power_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_por; power_state == 3'h1 |-> $past(!radio_por_active); endproperty
  a_por: assert property (p_por) else $error("por while active");
  property p_ck; $past(power_state) == 3'h1 |-> clk_request_o; endproperty
  a_ck: assert property (p_ck) else $error("no clock request");
  property p_up; $fell(radio_por_active) |-> ##[1:8] clk_request_o; endproperty
  a_up: assert property (p_up) else $error("late clock request");
  property p_sd; in_shutdown |-> !clk_request_oe && !host_wake_request_oe; endproperty
  a_sd: assert property (p_sd) else $error("driving in shutdown");
  property p_hs; !(uart_mode && handshake_en) [*2] |-> !host_wake_request_oe; endproperty
  a_hs: assert property (p_hs) else $error("handshake off but driven");
  property p_rs; $fell(in_shutdown) |-> power_state == 3'h0; endproperty
  a_rs: assert property (p_rs) else $error("shutdown exit not off");
  property p_lp; $rose(on_low_power_clock) |-> $past(power_state) == 3'h1; endproperty
  a_lp: assert property (p_lp) else $error("slow clock outside sleep");
  property p_off; radio_por_active [*2] |-> power_state == 3'h0; endproperty
  a_off: assert property (p_off) else $error("awake while disabled");
endmodule // bpw_checker
bind bpw_power_wake bpw_checker u_bpw_checker (.*);
`default_nettype wire

//--- verification/bpw_power_wake_tb.sv
// Bench: host model, falling-edge drive, queued checks.
// Assumes 100 MHz clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bpw_power_wake_tb;
  logic clk = 0, rst = 1, radio_enable_in = 0, low_power_osc_in = 0, want = 1, sw_host_wake = 0;
  logic uart_mode = 1, handshake_en = 1, dev_wake_active_low = 0, host_wake_active_low = 0;
  logic sw_sleep_req = 0, sw_shutdown = 0, sleep_criteria_met = 1, pkt_tx_active = 0;
  logic wlan_clk_need = 0, pkt_rx_active = 0, pkt_pa_active = 0, device_wake_request, host_awake;
  logic host_wake_request_o, host_wake_request_oe, clk_request_o, clk_request_oe, radio_por_active;
  logic core_awake, on_low_power_clock, in_shutdown;
  logic [31:0] sleep_interval = 3;
  logic [3:0] sw_pd_force = 0, rf_power_down;
  logic [2:0] power_state;
  logic [15:0] q[$];
  int mismatches = 0, total_checks = 0, cyc = 0;
  wire [7:0] obs = {rf_power_down, power_state[1:0], clk_request_o, host_awake};
  always #5 clk = ~clk;
  bpw_power_wake u_bpw_power_wake (.*);
  bpw_host_model u_bpw_host_model (.*);
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ex(input logic [7:0] m, input logic [7:0] v);
    q.push_back({m, v});
    wt(1);
  endtask
  task automatic cmp(input logic [15:0] e);
    total_checks++;
    if ((obs & e[15:8]) !== e[7:0]) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, obs, e[7:0]);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    // Look once the edge's updates have settled
    #2;
    if (q.size() > 0) cmp(q.pop_front());
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(44));
    wt(5);
    rst = 0;
    radio_enable_in = 1;
    wt(12);
    ex(8'h0f, 8'h06);
    pkt_tx_active = 1;
    repeat (3) begin
      sw_pd_force = 4'($urandom);
      wt(3);
      ex(8'h50, {1'b0, sw_pd_force[2], 1'b0, sw_pd_force[0], 4'h0});
    end
    {sw_sleep_req, sw_host_wake, pkt_tx_active} = 3'b110;
    for (int i = 0; i < 4; i++) begin
      {want, dev_wake_active_low, host_wake_active_low} = 3'(i + 4);
      wt(8);
      ex(8'hfd, 8'hf5);
      want = 0;
      wt(8);
      ex(8'h0c, 8'h08);
    end
    sw_sleep_req = 0;
    repeat (8) begin
      low_power_osc_in = ~low_power_osc_in;
      wt(6);
    end
    ex(8'h0c, 8'h04);
    sw_shutdown = 1;
    wt(6);
    ex(8'h0d, 8'h0c);
    sw_shutdown = 0;
    wt(15);
    ex(8'h0e, 8'h06);
    uart_mode = 0;
    wt(3);
    ex(8'h01, 8'h00);
    wrap_up;
  end
endmodule // bpw_power_wake_tb
`default_nettype wire
